//--- rtl/aic_core_ctrl.sv
// Purpose: register file and sequencing for input select, trims and core calibration
// Assumes: APB master per protocol, analog inputs as sampled 12-bit codes
// Notes:   sampling clock model is sys_clk, one sample per phase per edge
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ns
module aic_core_ctrl #(
    parameter int SingleFmtMax = 5,
    parameter int CalCycles    = aic_pkg::CalCycles,
    parameter int SwapCycles   = aic_pkg::SwapCycles
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog sample codes, already two's complement from the comparators
    input  wire logic [11:0] firstAnalogInput,
    input  wire logic [11:0] secondAnalogInput,
    // conversion outputs
    output logic      [11:0] coreASample,
    output logic      [11:0] coreBSample,
    output logic             sampleValid,
    output logic             sampleBothEdges,
    output logic             coreBOutOfPhase,
    output logic      [15:0] firstInputFullscaleTrim,
    output logic      [15:0] secondInputFullscaleTrim,
    output logic      [15:0] coreAOffsetApplied,
    output logic      [15:0] coreBOffsetApplied,
    output logic      [2:0]  activeChannels,
    output logic             calDone
);
    initial begin
        if (SingleFmtMax < 1 || SingleFmtMax > 31 || CalCycles < 1 || SwapCycles < 1)
            $error("aic_core_ctrl: bad parameter");
    end

    // registers
    logic [31:0] ctrlQ;
    logic [15:0] fsAQ, fsBQ;
    logic [15:0] offsAQ [4];
    logic [15:0] offsBQ [2];
    logic        inSelQ, dualInQ, calDoneQ;
    aic_pkg::aic_cal_t calStateQ;
    logic [31:0] calCntQ, swapCntQ;
    logic [1:0]  offlineQ;
    logic [11:0] in1M, in1S, in2M, in2S;

    // bus decode
    wire access   = psel && penable;
    // act once per transfer: the answer edge must not repeat the write
    wire wr       = access && pwrite && !pready;
    wire hitCtrl  = paddr == aic_pkg::CtrlOff;
    wire hitStat  = paddr == aic_pkg::StatusOff;
    wire hitFsA   = paddr == aic_pkg::FsTrimAOff;
    wire hitFsB   = paddr == aic_pkg::FsTrimBOff;
    wire hitOffsA = paddr >= aic_pkg::OffsATrimOff && paddr <= aic_pkg::OffsLastOff
                    && paddr[0] == 1'b0;
    wire [1:0] offsAIdx = 2'(( paddr - aic_pkg::OffsATrimOff) >> 1);
    wire hitOffsB0 = paddr == aic_pkg::OffsBOff;
    wire hitOffsB1 = paddr == aic_pkg::OffsBInBOff;
    wire mapped   = hitCtrl | hitStat | hitFsA | hitFsB | hitOffsA | hitOffsB0 | hitOffsB1;

    wire single   = ctrlQ[aic_pkg::CtrlSingleBit];
    wire bgCal    = ctrlQ[aic_pkg::CtrlBgCalBit];
    wire [aic_pkg::FmtW-1:0] fmt = ctrlQ[aic_pkg::CtrlFmtLsb +: aic_pkg::FmtW];
    wire fmtSingle = single && (32'(fmt) <= 32'(SingleFmtMax));
    wire calStart = wr && hitCtrl && pwdata[aic_pkg::CtrlCalGoBit]
                    && calStateQ == aic_pkg::CalIdle;
    wire calEnd   = calStateQ == aic_pkg::CalRun && calCntQ == 32'(CalCycles - 1);
    wire fgCalBusy = calStateQ == aic_pkg::CalRun && !bgCal;
    wire swapTick = swapCntQ == 32'(SwapCycles - 1);

    // core routing and trims
    wire [11:0] routedA = (single && !dualInQ) ? (inSelQ ? in2S : in1S) : in1S;
    wire [11:0] routedB = (single && !dualInQ) ? (inSelQ ? in2S : in1S) : in2S;
    wire        srcA    = single && !dualInQ ? inSelQ : 1'b0;
    wire        srcB    = single && !dualInQ ? inSelQ : 1'b1;
    wire [1:0]  aIdx    = {single, srcA};
    wire [15:0] offA    = offsAQ[aIdx];
    wire [15:0] offB    = offsBQ[srcB];
    // offset trims only take hold under foreground calibration
    wire [15:0] offAUse = bgCal ? aic_pkg::OffsRst : offA;
    wire [15:0] offBUse = bgCal ? aic_pkg::OffsRst : offB;
    wire [11:0] sampA   = routedA + offAUse[11:0];
    wire [11:0] sampB   = routedB + offBUse[11:0];

    wire [31:0] rdMux =
        hitCtrl   ? ctrlQ :
        hitStat   ? {26'h0000000, offlineQ, calStateQ == aic_pkg::CalRun, dualInQ,
                     inSelQ, calDoneQ} :
        hitFsA    ? {16'h0000, fsAQ} :
        hitFsB    ? {16'h0000, fsBQ} :
        hitOffsA  ? {16'h0000, offsAQ[offsAIdx]} :
        hitOffsB0 ? {16'h0000, offsBQ[0]} :
        hitOffsB1 ? {16'h0000, offsBQ[1]} : 32'h00000000;

    // input synchronisers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in1M <= 12'h000;
            in1S <= 12'h000;
            in2M <= 12'h000;
            in2S <= 12'h000;
        end else begin
            in1M <= firstAnalogInput;
            in1S <= in1M;
            in2M <= secondAnalogInput;
            in2S <= in2M;
        end
    end

    // register file
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlQ     <= {19'h00000, aic_pkg::FmtRst, 8'h00};
            fsAQ      <= aic_pkg::FsTrimRst;
            fsBQ      <= aic_pkg::FsTrimRst;
            offsAQ    <= '{default: aic_pkg::OffsRst};
            offsBQ    <= '{default: aic_pkg::OffsRst};
        end else if (wr) begin
            if (hitCtrl)
                ctrlQ <= pwdata & ~(32'h1 << aic_pkg::CtrlCalGoBit);
            if (hitFsA)
                fsAQ <= pwdata[15:0];
            if (hitFsB)
                fsBQ <= pwdata[15:0];
            if (hitOffsA)
                offsAQ[offsAIdx] <= pwdata[15:0];
            if (hitOffsB0)
                offsBQ[0] <= pwdata[15:0];
            if (hitOffsB1)
                offsBQ[1] <= pwdata[15:0];
        end
    end

    // calibration sequencer; selection latched only at calibration end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            calStateQ <= aic_pkg::CalIdle;
            calCntQ   <= 32'h00000000;
            inSelQ    <= 1'b0;
            dualInQ   <= 1'b0;
            calDoneQ  <= 1'b0;
        end else begin
            unique case (calStateQ)
                aic_pkg::CalIdle: begin
                    calCntQ <= 32'h00000000;
                    if (calStart) begin
                        calStateQ <= aic_pkg::CalRun;
                        calDoneQ  <= 1'b0;
                    end
                end
                aic_pkg::CalRun: begin
                    calCntQ <= calCntQ + 32'h1;
                    if (calEnd) begin
                        calStateQ <= aic_pkg::CalIdle;
                        inSelQ    <= ctrlQ[aic_pkg::CtrlInSelBit];
                        dualInQ   <= ctrlQ[aic_pkg::CtrlDualInBit] && fmtSingle;
                        calDoneQ  <= 1'b1;
                    end
                end
            endcase
        end
    end

    // channel rotation: one of three channels offline for calibration
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            swapCntQ <= 32'h00000000;
            offlineQ <= 2'd2;
        end else begin
            swapCntQ <= swapTick ? 32'h00000000 : swapCntQ + 32'h1;
            if (swapTick && bgCal)
                offlineQ <= (offlineQ == 2'd2) ? 2'd0 : offlineQ + 2'd1;
        end
    end

    // outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata    <= 32'h00000000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            coreASample <= 12'h000;
            coreBSample <= 12'h000;
            sampleValid <= 1'b0;
            sampleBothEdges <= 1'b0;
            coreBOutOfPhase <= 1'b0;
            firstInputFullscaleTrim  <= aic_pkg::FsTrimRst;
            secondInputFullscaleTrim <= aic_pkg::FsTrimRst;
            coreAOffsetApplied <= aic_pkg::OffsRst;
            coreBOffsetApplied <= aic_pkg::OffsRst;
            activeChannels <= 3'h3;
            calDone   <= 1'b0;
        end else begin
            // one wait state: ready in the cycle after the access phase starts
            pready    <= access && !pready;
            pslverr   <= access && !pready && !mapped;
            prdata    <= (access && !pwrite) ? rdMux : 32'h00000000;
            coreASample <= sampA;
            coreBSample <= sampB;
            sampleValid <= !fgCalBusy;
            sampleBothEdges <= single;
            coreBOutOfPhase <= single;
            firstInputFullscaleTrim  <= fsAQ;
            secondInputFullscaleTrim <= fsBQ;
            coreAOffsetApplied <= offAUse;
            coreBOffsetApplied <= offBUse;
            activeChannels <= ~(3'h1 << offlineQ);
            calDone   <= calDoneQ;
        end
    end
endmodule

//--- rtl/aic_pkg.sv
// Purpose: constants for the converter input, trim and calibration control block
// Assumes: APB slave, 32-bit data, one aligned word per register except core A offset trims, which sit on even halfword addresses
// Notes:   register offsets are byte addresses
//
// Behaviour
// - single-channel mode routes the selected analog input to the interleaved cores
// - new input selection takes effect only after a calibration following the change
// - dual-input single-channel: each core samples own input, core B out of phase
// - dual-input single-channel selectable only with a single-channel link format
// - each analog input has its own full-scale trim, applied only to it
// - core A offset: zero-degree trim in dual mode, ninety-degree in single mode
// - core B offset trim applies the same in single and dual modes
// - register offset trims are honoured in foreground calibration mode
// - three channels of two cores, two active, third calibrating, swapped live
// - single mode interleaves both active channels to double the sample rate
// - dual mode samples on rising edge, single mode on both edges
// - output samples are coded in two's complement
// - foreground calibration halts sampling, background keeps conversion running
package aic_pkg;
    localparam logic [11:0] CtrlOff      = 12'h000;
    localparam logic [11:0] StatusOff    = 12'h004;
    localparam logic [11:0] FsTrimAOff   = 12'h008;
    localparam logic [11:0] FsTrimBOff   = 12'h00C;
    localparam logic [11:0] OffsATrimOff = 12'h344;
    localparam logic [11:0] OffsLastOff  = 12'h34A;
    // core A: dual 0x344 (in A) 0x346 (in B); interleaved 0x348 (in A) 0x34A (in B)
    localparam logic [11:0] OffsBOff     = 12'h350;
    localparam logic [11:0] OffsBInBOff  = 12'h354;

    // control fields
    localparam int CtrlSingleBit  = 0;  // 1 = single-channel mode
    localparam int CtrlInSelBit   = 1;  // single input select, 0 = first input
    localparam int CtrlDualInBit  = 2;  // dual-input single-channel request
    localparam int CtrlBgCalBit   = 3;  // 1 = background calibration
    localparam int CtrlCalGoBit   = 4;  // write 1 starts calibration
    localparam int CtrlFmtLsb     = 8;
    localparam int FmtW           = 5;

    localparam logic [15:0] FsTrimRst = 16'hA000;
    localparam logic [15:0] OffsRst   = 16'h0000;
    localparam logic [FmtW-1:0] FmtRst = 5'h01;

    // timing: foreground calibration duration and channel swap period
    localparam int ClkMhz       = 20;
    localparam int CalTimeUs    = 100;
    localparam int CalCycles    = CalTimeUs * ClkMhz;
    localparam int SwapTimeUs   = 50;
    localparam int SwapCycles   = SwapTimeUs * ClkMhz;

    typedef enum logic [1:0] {CalIdle, CalRun} aic_cal_t;
endpackage

//--- verification/aic_core_ctrl_chk.sv
// Purpose: bus and behaviour checks beside the converter control block
// Assumes: CalCycles equals the value the block was built with
// Notes:   sees top-level ports only
`timescale 1ns/1ns
module aic_core_ctrl_chk #(
    parameter int CalCycles = 8
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // conversion side
    input wire logic        sampleValid,
    input wire logic        sampleBothEdges,
    input wire logic        coreBOutOfPhase,
    input wire logic [15:0] firstInputFullscaleTrim,
    input wire logic [15:0] secondInputFullscaleTrim,
    input wire logic [2:0]  activeChannels,
    input wire logic        calDone
);
    localparam int CalWin = CalCycles + 6;
    wire access = psel && penable && !pready;
    wire wrA    = access && pwrite && paddr == aic_pkg::FsTrimAOff;
    wire wrB    = access && pwrite && paddr == aic_pkg::FsTrimBOff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence calEnd;
        ##[1:CalWin] $rose(calDone);
    endsequence
    wait_state_a: assert property (access |=> pready) else $error("no answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
    odd_addr_err_a: assert property (access && paddr[0] |=> pslverr) else $error("odd ok");
    mode_edges_a: assert property (sampleBothEdges == coreBOutOfPhase)
        else $error("edge mode split");
    two_active_a: assert property ($countones(activeChannels) == 2)
        else $error("active count");
    fg_cal_len_a: assert property ($fell(sampleValid) |-> calEnd)
        else $error("halt too long");
    trim_a_own_a: assert property ($changed(firstInputFullscaleTrim) |->
        $past(wrA) || $past(wrA, 2)) else $error("first trim moved");
    trim_b_own_a: assert property ($changed(secondInputFullscaleTrim) |->
        $past(wrB) || $past(wrB, 2)) else $error("second trim moved");
endmodule

bind aic_core_ctrl aic_core_ctrl_chk #(.CalCycles(CalCycles)) aic_core_ctrl_chk_inst (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .sampleValid,
    .sampleBothEdges, .coreBOutOfPhase, .firstInputFullscaleTrim,
    .secondInputFullscaleTrim, .activeChannels, .calDone);

//--- verification/aic_rf_source.sv
// Purpose: RF source driving both analog inputs
// Assumes: levels are positive-minus-negative leg amplitudes
// Notes:   codes move only just after a rising edge
`timescale 1ns/1ns
module aic_rf_source (
    // clock
    input  wire logic        sys_clk,
    // requested levels
    input  wire logic [11:0] levelA,
    input  wire logic [11:0] levelB,
    // codes at the converter
    output logic      [11:0] firstAnalogInput,
    output logic      [11:0] secondAnalogInput
);
    // negative leg above positive gives a negative code
    always_ff @(posedge sys_clk) begin
        firstAnalogInput  <= levelA;
        secondAnalogInput <= levelB;
    end
endmodule

//--- verification/adc_input_core_config_control_tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: calibration 8 cycles, swap 4 cycles
// Notes:   registers over APB, source levels from the RF model
`timescale 1ns/1ns
module adc_input_core_config_control_tb_top;
    logic        sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, levelA = 12'h100, levelB = 12'hF00;
    logic [31:0] pwdata = 32'h0, prdata, rdVal;
    logic        pready, pslverr, errVal, sampleValid, sampleBothEdges, coreBOutOfPhase, calDone;
    logic [11:0] firstAnalogInput, secondAnalogInput, coreASample, coreBSample;
    logic [15:0] firstInputFullscaleTrim, secondInputFullscaleTrim;
    logic [15:0] coreAOffsetApplied, coreBOffsetApplied;
    logic [2:0]  activeChannels, chanSeen;
    int          mismatches = 0, checkCount = 0, n;

    aic_core_ctrl #(.CalCycles(8), .SwapCycles(4)) aic_core_ctrl_inst (
        .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .firstAnalogInput, .secondAnalogInput, .coreASample, .coreBSample,
        .sampleValid, .sampleBothEdges, .coreBOutOfPhase, .firstInputFullscaleTrim,
        .secondInputFullscaleTrim, .coreAOffsetApplied, .coreBOffsetApplied,
        .activeChannels, .calDone);
    aic_rf_source aic_rf_source_inst (
        .sys_clk, .levelA, .levelB, .firstAnalogInput, .secondAnalogInput);

    initial forever #25 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] dat);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= adr;
        pwdata  <= dat;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            mismatches++;
            test_done;
        end
        rdVal   = prdata;
        errVal  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // fg says whether sampling should halt meanwhile
    task automatic cal(input logic [31:0] ctrl, input logic fg);
        apb(1'b1, aic_pkg::CtrlOff, ctrl | 32'h10);
        repeat (2) @(posedge sys_clk);
        chk(sampleValid, !fg);
        for (n = 0; calDone !== 1'b1 && n < 40; n++) @(posedge sys_clk);
        chk(calDone, 1'b1);
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #(4000 * 50);
        mismatches++;
        test_done;
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, aic_pkg::CtrlOff, 32'h0);
        chk(rdVal, 32'h100);
        apb(1'b0, 12'h345, 32'h0);
        chk(errVal, 1'b1);
        apb(1'b1, aic_pkg::FsTrimAOff, 32'h1234);
        apb(1'b1, aic_pkg::OffsATrimOff, 32'h11);
        apb(1'b1, 12'h348, 32'h22);
        apb(1'b1, aic_pkg::OffsBOff, 32'h33);
        repeat (4) @(posedge sys_clk);
        chk(firstInputFullscaleTrim, 16'h1234);
        chk(secondInputFullscaleTrim, 16'hA000);
        chk(coreAOffsetApplied, 16'h11);
        chk(coreASample, 12'h111);
        chk(sampleBothEdges, 1'b0);
        apb(1'b1, aic_pkg::CtrlOff, 32'h103);
        repeat (4) @(posedge sys_clk);
        chk(coreAOffsetApplied, 16'h22);
        chk(coreBOffsetApplied, 16'h33);
        chk(sampleBothEdges, 1'b1);
        chk(coreBOutOfPhase, 1'b1);
        chk(coreASample, 12'h122);
        cal(32'h103, 1'b1);
        chk(coreASample, 12'hF00);
        cal(32'h607, 1'b1);
        apb(1'b0, aic_pkg::StatusOff, 32'h0);
        chk(rdVal[2], 1'b0);
        cal(32'h107, 1'b1);
        apb(1'b0, aic_pkg::StatusOff, 32'h0);
        chk(rdVal[2], 1'b1);
        chk(coreASample, 12'h122);
        chk(coreBSample, 12'hF00);
        cal(32'h109, 1'b0);
        chk(coreAOffsetApplied, 16'h0);
        chanSeen = activeChannels;
        for (n = 0; activeChannels === chanSeen && n < 12; n++) @(posedge sys_clk);
        chk(activeChannels !== chanSeen, 1'b1);
        test_done;
    end
endmodule
